// *** design/csmc_color_converter.sv ***
/*
 * color_converter: fixed-point 3x3 matrix plus offset, parallel or
 * sequential plane transport, rounding and overflow on the output.
 * assumes one clock, inputs synchronous to it, and an upstream that
 * spaces sequential triplets by at least three cycles.
 */
`timescale 1ns/10ps
`include "csmc_regs.svh"

module csmc_color_converter
  import csmc_pkg::*;
#(
  parameter int IN_W = `CSMC_DEF_IN_W,
  parameter int COEF_W = `CSMC_DEF_COEF_W,
  parameter int BPOINT = `CSMC_DEF_BPOINT,
  parameter int OUT_W = `CSMC_DEF_OUT_W,
  parameter bit IN_SIGNED = 1'b0,
  parameter bit OUT_SIGNED = 1'b0,
  parameter csmc_preset_t PRESET = CSMC_P_RGB2YCC_SD,
  parameter csmc_arch_t ARCH = CSMC_ARCH_PAR,
  parameter csmc_round_t ROUND_MODE = CSMC_RND_HALF_UP,
  parameter csmc_ovf_t OVF_MODE = CSMC_OVF_SAT,
  // micro units: row r holds three coefficients then the offset
  parameter int CUSTOM_TAB [0:`CSMC_TAB_COLS-1] = '{default: 0}
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [IN_W-1:0] in_plane0,
  input wire logic [IN_W-1:0] in_plane1,
  input wire logic [IN_W-1:0] in_plane2,
  output logic out_valid,
  output logic [OUT_W-1:0] out_plane0,
  output logic [OUT_W-1:0] out_plane1,
  output logic [OUT_W-1:0] out_plane2
);
  localparam int FULL_W = IN_W + COEF_W + `CSMC_FULL_EXTRA;
  localparam int NP = `CSMC_PLANES;
  localparam int RC = `CSMC_ROW_COLS;
  localparam int RW = FULL_W + 2;
  // output slice low index; bits below it feed rounding
  localparam int LO = (OUT_W >= FULL_W) ? 0 :
                      (OUT_W <= FULL_W - BPOINT) ? BPOINT :
                      FULL_W - OUT_W;
  localparam logic signed [RW-1:0] HALF_M = (LO > 0) ? (RW'(1) <<< (LO - 1)) : '0;
  localparam logic signed [RW-1:0] REST_M = (LO > 1) ? (HALF_M - RW'(1)) : '0;
  localparam logic signed [RW-1:0] MAXV = OUT_SIGNED ? ((RW'(1) <<< (OUT_W - 1)) - RW'(1))
                                                     : ((RW'(1) <<< OUT_W) - RW'(1));
  localparam logic signed [RW-1:0] MINV = OUT_SIGNED ? -(RW'(1) <<< (OUT_W - 1)) : '0;

  // coefficient table in micro units, rows as output planes
  localparam int PRESET_TAB [0:`CSMC_NUM_PRESETS*`CSMC_TAB_COLS-1] = '{
    257000, 504000, 98000, 16000000,
    -148000, -291000, 439000, 128000000,
    439000, -368000, -71000, 128000000,
    183000, 614000, 62000, 16000000,
    -101000, -338000, 439000, 128000000,
    439000, -399000, -40000, 128000000,
    299000, 587000, 114000, 0,
    -172000, -339000, 511000, 128000000,
    511000, -428000, -83000, 128000000,
    213000, 715000, 72000, 0,
    -117000, -394000, 511000, 128000000,
    511000, -464000, -47000, 128000000,
    1164000, 0, 1596000, -222912000,
    1164000, -391000, -813000, 135488000,
    1164000, 2018000, 0, -276928000,
    1164000, 0, 1793000, -248128000,
    1164000, -213000, -534000, 76992000,
    1164000, 2115000, 0, -289344000,
    1000000, 0, 1371000, -175488000,
    1000000, -336000, -698000, 132352000,
    1000000, 1732000, 0, -221696000,
    1000000, 0, 1540000, -197120000,
    1000000, -183000, -459000, 82176000,
    1000000, 1816000, 0, -232448000,
    1000000, 0, 1140000, 0,
    1000000, -395000, -581000, 0,
    1000000, -2032000, 0, 0,
    299000, 587000, 114000, 0,
    -147000, -289000, 436000, 0,
    615000, -515000, -100000, 0,
    1000000, 956000, 621000, 0,
    1000000, -272000, -647000, 0,
    1000000, -1107000, 1704000, 0,
    299000, 587000, 114000, 0,
    596000, -275000, -321000, 0,
    212000, -523000, 311000, 0,
    1000000, 0, 0, 0,
    0, -544639, 838671, 0,
    0, 838671, 544639, 0
  };

  function automatic longint tab_at(input int i);
    if (PRESET == CSMC_P_CUSTOM) begin
      return longint'(CUSTOM_TAB[i]);
    end
    return longint'(PRESET_TAB[int'(PRESET) * `CSMC_TAB_COLS + i]);
  endfunction

  // nearest integer of micro value times 2^BPOINT; rounding keeps presets symmetric
  function automatic longint scaled(input int i);
    longint v;
    v = tab_at(i) * (longint'(1) <<< BPOINT);
    if (v >= 0) begin
      return (v + `CSMC_MICRO_HALF) / `CSMC_MICRO;
    end
    return -((-v + `CSMC_MICRO_HALF) / `CSMC_MICRO);
  endfunction

  // sequential collection
  logic [1:0] cnt_reg;
  logic [IN_W-1:0] col_reg [0:1];
  // pipeline
  logic v1_reg, v2_reg, v3_reg;
  logic [IN_W-1:0] in_reg [0:NP-1];
  logic signed [FULL_W-1:0] prod_reg [0:NP*NP-1];
  logic signed [FULL_W-1:0] sum_reg [0:NP-1];
  logic [OUT_W-1:0] hold_reg [0:1];
  logic [1:0] ser_reg;
  logic [OUT_W-1:0] out_reg [0:NP-1];

  logic signed [IN_W:0] in_ext [0:NP-1];
  logic signed [FULL_W-1:0] exp_sum [0:NP-1];
  logic signed [RW-1:0] rnd_w [0:NP-1];
  logic signed [RW-1:0] trunc_w [0:NP-1];
  logic [OUT_W-1:0] res_w [0:NP-1];

  wire logic seq_last = in_valid && (cnt_reg == 2'(`CSMC_SEQ_LAST));

  genvar r, c;
  generate
    for (c = 0; c < NP; c++) begin : g_ext
      assign in_ext[c] = IN_SIGNED ? {in_reg[c][IN_W-1], in_reg[c]} : {1'b0, in_reg[c]};
    end
    for (r = 0; r < NP; r++) begin : g_row
      localparam longint OFFL = scaled(r * RC + NP);
      localparam logic signed [FULL_W-1:0] OFF = OFFL[FULL_W-1:0];
      logic signed [FULL_W-1:0] tmp_sum [0:NP];
      assign tmp_sum[0] = OFF;
      for (c = 0; c < NP; c++) begin : g_col
        localparam longint CL = scaled(r * RC + c);
        localparam logic signed [COEF_W-1:0] CW = CL[COEF_W-1:0];
        logic signed [IN_W+COEF_W:0] prod_w;
        assign prod_w = in_ext[c] * CW;
        assign tmp_sum[c+1] = tmp_sum[c] + FULL_W'(prod_w);
        always_ff @(posedge ref_clk or posedge rst) begin
          if (rst) begin
            prod_reg[r*NP+c] <= '0;
          end else if (v1_reg) begin
            prod_reg[r*NP+c] <= FULL_W'(prod_w);
          end
        end
      end
      assign exp_sum[r] = tmp_sum[NP];

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          sum_reg[r] <= '0;
        end else if (v2_reg) begin
          sum_reg[r] <= prod_reg[r*NP] + prod_reg[r*NP+1] + prod_reg[r*NP+2] + OFF;
        end
      end

      // lsb treatment on the bits below LO
      logic signed [RW-1:0] sx;
      logic signed [RW-1:0] q;
      logic half, rest, neg, rinc;
      assign sx = RW'(sum_reg[r]);
      assign q = sx >>> LO;
      assign half = |(sx & HALF_M);
      assign rest = |(sx & REST_M);
      assign neg = sx[RW-1];
      assign rinc = (ROUND_MODE == CSMC_RND_HALF_UP) ? half :
                    (ROUND_MODE == CSMC_RND_AWAY) ? (half && (rest || !neg)) :
                    (ROUND_MODE == CSMC_RND_TOWARD) ? (half && (rest || neg)) :
                    (ROUND_MODE == CSMC_RND_EVEN) ? (half && (rest || q[0])) : 1'b0;
      assign trunc_w[r] = q;
      assign rnd_w[r] = q + RW'(rinc);
      // saturation clamps by sign; wrap simply drops the upper bits
      assign res_w[r] = (OVF_MODE == CSMC_OVF_WRAP) ? rnd_w[r][OUT_W-1:0] :
                        (rnd_w[r] > MAXV) ? MAXV[OUT_W-1:0] :
                        (rnd_w[r] < MINV) ? MINV[OUT_W-1:0] : rnd_w[r][OUT_W-1:0];

      sum_model_a: assert property (@(posedge ref_clk) disable iff (rst)
        v3_reg |-> sum_reg[r] == $past(exp_sum[r], 2))
        else $error("matrix sum does not match inputs");
    end
  endgenerate

  // input capture: whole triplet in parallel, collected plane by plane otherwise
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      col_reg[0] <= '0;
      col_reg[1] <= '0;
      in_reg[0] <= '0;
      in_reg[1] <= '0;
      in_reg[2] <= '0;
      v1_reg <= 1'b0;
    end else if (ARCH == CSMC_ARCH_PAR) begin
      v1_reg <= in_valid;
      if (in_valid) begin
        in_reg[0] <= in_plane0;
        in_reg[1] <= in_plane1;
        in_reg[2] <= in_plane2;
      end
    end else begin
      v1_reg <= seq_last;
      if (seq_last) begin
        in_reg[0] <= col_reg[0];
        in_reg[1] <= col_reg[1];
        in_reg[2] <= in_plane0;
        cnt_reg <= '0;
      end else if (in_valid) begin
        col_reg[cnt_reg[0]] <= in_plane0;
        cnt_reg <= cnt_reg + 2'd1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      v2_reg <= 1'b0;
      v3_reg <= 1'b0;
    end else begin
      v2_reg <= v1_reg;
      v3_reg <= v2_reg;
    end
  end

  // output stage; sequential mode replays planes 1 and 2 from hold
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_reg[0] <= '0;
      out_reg[1] <= '0;
      out_reg[2] <= '0;
      hold_reg[0] <= '0;
      hold_reg[1] <= '0;
      ser_reg <= '0;
      out_valid <= 1'b0;
    end else if (ARCH == CSMC_ARCH_PAR) begin
      out_valid <= v3_reg;
      if (v3_reg) begin
        out_reg[0] <= res_w[0];
        out_reg[1] <= res_w[1];
        out_reg[2] <= res_w[2];
      end
    end else if (v3_reg) begin
      out_reg[0] <= res_w[0];
      hold_reg[0] <= res_w[1];
      hold_reg[1] <= res_w[2];
      ser_reg <= 2'(`CSMC_SEQ_LAST);
      out_valid <= 1'b1;
    end else if (ser_reg != 2'd0) begin
      out_reg[0] <= hold_reg[0];
      hold_reg[0] <= hold_reg[1];
      ser_reg <= ser_reg - 2'd1;
      out_valid <= 1'b1;
    end else begin
      out_valid <= 1'b0;
    end
  end

  assign out_plane0 = out_reg[0];
  assign out_plane1 = out_reg[1];
  assign out_plane2 = out_reg[2];

  // out_valid is launched three edges after capture, so it is first seen on the fourth
  lat_par_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ARCH == CSMC_ARCH_PAR && in_valid) |-> ##4 out_valid)
    else $error("parallel result missing four edges after input");

  nolat_par_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ARCH == CSMC_ARCH_PAR && !in_valid) |-> ##4 !out_valid)
    else $error("parallel result without input");

  // a triplet completing three edges later legally keeps valid high
  seq_burst_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ARCH == CSMC_ARCH_SEQ && seq_last) |-> ##4 out_valid [*3]
      ##1 (!out_valid || $past(seq_last, 4)))
    else $error("sequential burst is not three planes");

  seq_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ARCH == CSMC_ARCH_SEQ) |-> (out_plane1 == '0 && out_plane2 == '0))
    else $error("unused planes driven in sequential mode");

  seq_count_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ARCH == CSMC_ARCH_SEQ && in_valid && cnt_reg == 2'd0) |=> cnt_reg == 2'd1)
    else $error("plane counter did not advance");

  sat_high_a: assert property (@(posedge ref_clk) disable iff (rst)
    (OVF_MODE == CSMC_OVF_SAT && v3_reg && rnd_w[0] > MAXV) |=> out_plane0 == MAXV[OUT_W-1:0])
    else $error("overflow not saturated to maximum");

  sat_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    (OVF_MODE == CSMC_OVF_SAT && v3_reg && rnd_w[0] < MINV) |=> out_plane0 == MINV[OUT_W-1:0])
    else $error("underflow not saturated to minimum");

  round_trunc_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ARCH == CSMC_ARCH_PAR && v3_reg
      && (ROUND_MODE == CSMC_RND_TRUNC || !g_row[1].half)
      && rnd_w[1] <= MAXV && rnd_w[1] >= MINV)
      |=> out_plane1 == $past(trunc_w[1][OUT_W-1:0]))
    else $error("truncation result wrong");

  round_even_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ROUND_MODE == CSMC_RND_EVEN && v3_reg && g_row[0].half && !g_row[0].rest
      && rnd_w[0] <= MAXV && rnd_w[0] >= MINV)
      |=> !out_plane0[0])
    else $error("exact half not rounded to even");

  seq_replay_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ARCH == CSMC_ARCH_SEQ && !v3_reg && ser_reg != 2'd0)
      |=> (out_valid && out_plane0 == $past(hold_reg[0])))
    else $error("held plane not replayed in order");
endmodule

// *** design/csmc_pkg.sv ***
/*
 * types of the colour space matrix converter: presets, architecture,
 * lsb rounding and msb overflow treatments.
 * assumes nothing beyond the constants header.
 */
package csmc_pkg;
  typedef enum {
    CSMC_P_RGB2YCC_SD, CSMC_P_RGB2YCC_HD, CSMC_P_RGB2STU_SD, CSMC_P_RGB2STU_HD,
    CSMC_P_YCC_SD2RGB, CSMC_P_YCC_HD2RGB, CSMC_P_YCC_SD2STU, CSMC_P_YCC_HD2STU,
    CSMC_P_YUV2RGB, CSMC_P_RGB2YUV, CSMC_P_YIQ2RGB, CSMC_P_RGB2YIQ,
    CSMC_P_YIQ2YUV, CSMC_P_CUSTOM
  } csmc_preset_t;

  typedef enum {CSMC_ARCH_PAR, CSMC_ARCH_SEQ} csmc_arch_t;

  typedef enum {
    CSMC_RND_TRUNC, CSMC_RND_HALF_UP, CSMC_RND_AWAY, CSMC_RND_TOWARD, CSMC_RND_EVEN
  } csmc_round_t;

  typedef enum {CSMC_OVF_SAT, CSMC_OVF_WRAP} csmc_ovf_t;
endpackage

// *** design/csmc_regs.svh ***
/*
 * constants for the colour space matrix converter: default widths,
 * coefficient table layout, pipeline depths.
 * assumes it is included by its bare name into the core; the package does not include it.
 */
`ifndef CSMC_REGS_SVH
`define CSMC_REGS_SVH

`define CSMC_DEF_IN_W 8
`define CSMC_DEF_COEF_W 14
`define CSMC_DEF_BPOINT 10
`define CSMC_DEF_OUT_W 8
`define CSMC_FULL_EXTRA 2
`define CSMC_MICRO 1000000
`define CSMC_MICRO_HALF 500000
`define CSMC_ROW_COLS 4
`define CSMC_TAB_COLS 12
`define CSMC_NUM_PRESETS 13
`define CSMC_PLANES 3
`define CSMC_LAT_PAR 3
`define CSMC_SEQ_LAST 2

`endif

// *** test/csmc_video_side.sv ***
/*
 * video side model: upstream pixel source and downstream result catcher
 * for one converter instance, parallel or sequential plane transport.
 * assumes 8-bit planes, no backpressure, and a caller that waits for reset.
 */
`timescale 1ns/10ps
module csmc_video_side #(
  parameter bit SEQ = 1'b0
) (
  input wire logic ref_clk,
  output logic in_valid,
  output logic [7:0] in_plane0,
  output logic [7:0] in_plane1,
  output logic [7:0] in_plane2,
  input wire logic out_valid,
  input wire logic [7:0] out_plane0,
  input wire logic [7:0] out_plane1,
  input wire logic [7:0] out_plane2
);
  logic [23:0] res_q [$];

  initial begin
    in_valid = 1'b0;
    in_plane0 = 8'h00;
    in_plane1 = 8'h00;
    in_plane2 = 8'h00;
  end

  task automatic drive(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    @(posedge ref_clk);
    in_valid <= 1'b1;
    in_plane0 <= a;
    in_plane1 <= b;
    in_plane2 <= c;
  endtask

  // idle data keeps toggling so a stale value never looks valid
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      in_valid <= 1'b0;
      in_plane0 <= ~in_plane0;
      in_plane1 <= ~in_plane1;
      in_plane2 <= ~in_plane2;
    end
  endtask

  // unused planes carry junk in sequential mode
  task automatic send(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
                      input int gap);
    if (SEQ) begin
      drive(a, ~a, ~a);
      idle(gap);
      drive(b, ~b, ~b);
      idle(gap);
      drive(c, ~c, ~c);
    end else begin
      drive(a, b, c);
    end
  endtask

  // empty queue yields unknowns so a missing result never matches
  function automatic logic [23:0] take();
    if (res_q.size() == 0) begin
      return 24'hXXXXXX;
    end
    return res_q.pop_front();
  endfunction

  always @(posedge ref_clk) begin
    if (out_valid === 1'b1) begin
      res_q.push_back({out_plane0, out_plane1, out_plane2});
    end
  end
endmodule

// *** test/test_csmc_color_converter.sv ***
/*
 * self-checking bench: sdtv preset in parallel, sdtv inverse preset in
 * sequence, custom table with even rounding and saturation.
 * assumes the package, header and video side model are compiled first.
 */
`timescale 1ns/10ps
module test_csmc_color_converter import csmc_pkg::*; ;
  typedef struct packed {logic [7:0] i0; logic [7:0] i1; logic [7:0] i2; logic [23:0] exp;} csmc_row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic p_vld, p_ov, s_vld, s_ov, c_vld, c_ov;
  logic [7:0] p_i0, p_i1, p_i2, p_o0, p_o1, p_o2, s_i0, s_i1, s_i2, s_o0, s_o1, s_o2;
  logic [7:0] c_i0, c_i1, c_i2, c_o0, c_o1, c_o2;
  int mismatches = 0;
  int total_checks = 0;
  csmc_row_t rows [0:4] = '{'{8'h00, 8'h00, 8'h00, 24'h108080}, '{8'hFF, 8'hFF, 8'hFF, 24'hEB8080},
    '{8'hFF, 8'h00, 8'h00, 24'h515AF0}, '{8'h00, 8'hFF, 8'h00, 24'h903622},
    '{8'h00, 8'h00, 8'hFF, 24'h29F06E}};
  logic [23:0] seq_exp [0:5] = '{24'h000000, 24'h870000, 24'h000000, 24'hFF0000, 24'h7D0000,
    24'hFF0000};

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  csmc_color_converter DUT (.ref_clk(ref_clk), .rst(rst), .in_valid(p_vld), .in_plane0(p_i0),
    .in_plane1(p_i1), .in_plane2(p_i2), .out_valid(p_ov), .out_plane0(p_o0),
    .out_plane1(p_o1), .out_plane2(p_o2));
  csmc_color_converter #(.PRESET(CSMC_P_YCC_SD2RGB), .ARCH(CSMC_ARCH_SEQ)) DUT_SEQ (
    .ref_clk(ref_clk), .rst(rst), .in_valid(s_vld), .in_plane0(s_i0), .in_plane1(s_i1),
    .in_plane2(s_i2), .out_valid(s_ov), .out_plane0(s_o0), .out_plane1(s_o1),
    .out_plane2(s_o2));
  // custom rows: half, unity plus 250, minus unity
  csmc_color_converter #(.PRESET(CSMC_P_CUSTOM), .ROUND_MODE(CSMC_RND_EVEN),
    .CUSTOM_TAB('{500000, 0, 0, 0, 1000000, 0, 0, 250000000, 0, -1000000, 0, 0})) DUT_CUS (
    .ref_clk(ref_clk), .rst(rst), .in_valid(c_vld), .in_plane0(c_i0), .in_plane1(c_i1),
    .in_plane2(c_i2), .out_valid(c_ov), .out_plane0(c_o0), .out_plane1(c_o1),
    .out_plane2(c_o2));
  csmc_video_side src_par (.ref_clk(ref_clk), .in_valid(p_vld), .in_plane0(p_i0),
    .in_plane1(p_i1), .in_plane2(p_i2), .out_valid(p_ov), .out_plane0(p_o0),
    .out_plane1(p_o1), .out_plane2(p_o2));
  csmc_video_side #(.SEQ(1'b1)) src_seq (.ref_clk(ref_clk), .in_valid(s_vld),
    .in_plane0(s_i0), .in_plane1(s_i1), .in_plane2(s_i2), .out_valid(s_ov),
    .out_plane0(s_o0), .out_plane1(s_o1), .out_plane2(s_o2));
  csmc_video_side src_cus (.ref_clk(ref_clk), .in_valid(c_vld), .in_plane0(c_i0),
    .in_plane1(c_i1), .in_plane2(c_i2), .out_valid(c_ov), .out_plane0(c_o0),
    .out_plane1(c_o1), .out_plane2(c_o2));

  task automatic chk24(input string name, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // whole run is about sixty cycles; fifty times that is a hang
  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    // back to back rows stress full throughput
    foreach (rows[k]) src_par.send(rows[k].i0, rows[k].i1, rows[k].i2, 0);
    src_par.idle(6);
    foreach (rows[k]) chk24("parallel result", rows[k].exp, src_par.take());
    // second triplet spaced by idle cycles
    src_seq.send(8'h00, 8'h00, 8'h00, 0);
    src_seq.send(8'hFF, 8'hFF, 8'hFF, 2);
    src_seq.idle(8);
    foreach (seq_exp[k]) chk24("sequential plane", seq_exp[k], src_seq.take());
    src_cus.send(8'h07, 8'h03, 8'h00, 0);
    src_cus.send(8'h05, 8'h00, 8'h00, 0);
    src_cus.idle(6);
    chk24("custom even sat", 24'h04FF00, src_cus.take());
    chk24("custom even exact", 24'h02FF00, src_cus.take());
    // isolated pixel to pin down the latency
    src_par.send(8'hFF, 8'h00, 8'h00, 0);
    src_par.idle(1);
    for (int n = 1; n <= 5; n++) begin
      @(negedge ref_clk);
      chk1("parallel valid timing", n == 4, p_ov);
    end
    chk24("isolated result", 24'h515AF0, src_par.take());
    // reset must clear held outputs at once, not at the next edge
    @(posedge ref_clk);
    rst <= 1'b1;
    #1;
    chk24("reset outputs", 24'h000000, {p_o0, p_o1, p_o2});
    chk1("reset valid", 1'b0, p_ov);
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    src_par.send(rows[2].i0, rows[2].i1, rows[2].i2, 0);
    src_par.idle(6);
    chk24("after reset", rows[2].exp, src_par.take());
    end_sim();
  end
endmodule
